/* apc_axis_params.sv */
//
// Behaviour
// R1: Command 08h loads signed 32-bit circle center offset per axis.
// R2: Command 09h overwrites commanded position counter, any time.
// R3: Commanded counter follows plus and minus output pulses.
// R4: Command 0Ah overwrites encoder position counter, any time.
// R5: Encoder counter follows quadrature or up/down inputs by mode.
// R6: Command 0Bh loads upper compare; drives status bit and pin.
// R7: Command 0Ch loads lower compare; drives status bit and pin.
// R8: Command 0Dh loads accel offset; reset value is 8.
// R9: Host sets accel offset zero for slow fixed-pulse moves.
// R10: Command 0Eh loads 16-bit deceleration increasing rate.
// R11: Command 60h copies both data words into extension mode.
// R12: Extension bit 0 with input two active stops and clears encoder.
// R13: Extension bit 1 inverts encoder counting direction.
// R14: Extension bit 2 swaps plus and minus pulse outputs.
// R15: Bits 3 and 4 enable triangle prevention and ring wrap.
// R16: Bit 5 makes home end pull interrupt low, set flag bit 8.
// R17: Reading interrupting axis event status clears it, releases line.
// R18: Bit 7 selects speed priority for S-curve profiles.
// R19: Bits 12..8 enable filters per input group; first axis globals.
// R20: Bits 15..13 choose filter time constant, doubling per code; here code 1 is 128x code 0, then doubling.
// R21: Command 61h loads 16-bit low home search speed.
// R22: Command 64h copies both data words into sync action mode.
// R23: Host waits 250 ns between commands.
// R24: Data goes to every axis selected in the command write.
//
// File holds the command interpreter and per-axis parameter registers
// Assumes host strobes are synchronous one-cycle pulses
module apc_axis_params
    import apc_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [15:0] write_data_low, // Staged data word low
    input wire logic [15:0] write_data_high, // Staged data word high
    input wire logic [7:0] cmd_code, // Command code
    input wire logic [apc_pkg::AXES-1:0] cmd_axes, // Axis selection
    input wire logic cmd_wr, // Command write strobe
    output logic cmd_busy, // Command still being taken
    input wire logic [apc_pkg::AXES-1:0] pulse_plus, // Plus output pulse
    input wire logic [apc_pkg::AXES-1:0] pulse_minus, // Minus output pulse
    input wire logic [apc_pkg::AXES-1:0] enc_updown_mode, // 1 up/down, 0 A/B
    input wire logic [apc_pkg::AXES-1:0] encoder_plus_input, // Phase A or up
    input wire logic [apc_pkg::AXES-1:0] encoder_minus_input, // Phase B or down
    input wire logic [apc_pkg::AXES-1:0] general_input_two, // Input two, raw
    input wire logic [apc_pkg::AXES-1:0] input_two_stop_enable, // Stop enable
    input wire logic [apc_pkg::AXES-1:0] input_two_active_level, // Active level
    input wire logic [apc_pkg::AXES-1:0] cmp_use_encoder, // Compare source
    input wire logic [apc_pkg::AXES-1:0] home_search_done, // Home end pulse
    input wire logic [apc_pkg::AXES-1:0] event_status_read, // Status read strobe
    output logic [apc_pkg::AXES-1:0] stop_request, // Stop drive pulse
    output logic [apc_pkg::AXES-1:0] plus_pulse_out, // Plus pulse pin
    output logic [apc_pkg::AXES-1:0] minus_pulse_out, // Minus pulse pin
    output logic [apc_pkg::AXES-1:0] upper_compare_pin, // Upper compare
    output logic [apc_pkg::AXES-1:0] lower_compare_pin, // Lower compare
    output logic [apc_pkg::AXES*2-1:0] compare_status_register, // Cmp bits
    output logic [apc_pkg::AXES*16-1:0] event_status_register, // Events
    output logic interrupt_out_low_o, // Interrupt drive value
    output logic interrupt_out_low_oe_n, // Interrupt enable, low drives
    output logic [apc_pkg::AXES*32-1:0] commanded_position_counter, // Cmd pos
    output logic [apc_pkg::AXES*32-1:0] encoder_position_counter, // Enc pos
    output logic [apc_pkg::AXES*32-1:0] circle_center, // Center offsets
    output logic [apc_pkg::AXES*32-1:0] upper_compare_value, // Upper cmp
    output logic [apc_pkg::AXES*32-1:0] lower_compare_value, // Lower cmp
    output logic [apc_pkg::AXES*16-1:0] accel_counter_offset, // Offset
    output logic [apc_pkg::AXES*16-1:0] decel_increase_rate, // Rate
    output logic [apc_pkg::AXES*16-1:0] home_search_low_speed, // Speed
    output logic [apc_pkg::AXES*16-1:0] extension_mode_low, // Ext low
    output logic [apc_pkg::AXES*16-1:0] extension_mode_high, // Ext high
    output logic [apc_pkg::AXES*16-1:0] sync_action_mode_low, // Sync low
    output logic [apc_pkg::AXES*16-1:0] sync_action_mode_high, // Sync high
    output logic [apc_pkg::AXES-1:0] triangle_prevention, // Profile flag
    output logic [apc_pkg::AXES-1:0] variable_ring_enable, // Ring wrap flag
    output logic [apc_pkg::AXES-1:0] speed_priority_scurve // S-curve flag
);
    // ***************************************************************
    // Reset release and command timing
    // ***************************************************************
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    localparam logic [3:0] BUSY_LOAD = 4'(CMD_BUSY_CYC);
    logic [3:0] busy_q;
    assign cmd_busy = busy_q != 4'h0;
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            busy_q <= 4'h0;
        end else if (cmd_wr) begin
            busy_q <= BUSY_LOAD; // R23
        end else if (cmd_busy) begin
            busy_q <= busy_q - 4'h1;
        end
    end

    // ***************************************************************
    // Command decode
    // ***************************************************************
    logic [31:0] wdata;
    logic [15:0] neg_one;
    assign wdata = {write_data_high, write_data_low};
    assign neg_one = 16'hffff;
    logic dec_center, dec_cmd_pos, dec_enc_pos, dec_upper, dec_lower;
    logic dec_acc, dec_dec, dec_ext, dec_home, dec_sync;
    assign dec_center = cmd_wr && cmd_code == CMD_CENTER;
    assign dec_cmd_pos = cmd_wr && cmd_code == CMD_CMD_POS;
    assign dec_enc_pos = cmd_wr && cmd_code == CMD_ENC_POS;
    assign dec_upper = cmd_wr && cmd_code == CMD_UPPER;
    assign dec_lower = cmd_wr && cmd_code == CMD_LOWER;
    assign dec_acc = cmd_wr && cmd_code == CMD_ACC_OFS;
    assign dec_dec = cmd_wr && cmd_code == CMD_DEC_RATE;
    assign dec_ext = cmd_wr && cmd_code == CMD_EXT_MODE;
    assign dec_home = cmd_wr && cmd_code == CMD_HOME_SPD;
    assign dec_sync = cmd_wr && cmd_code == CMD_SYNC_MODE;

    // ***************************************************************
    // Filter time base shared by all axes
    // ***************************************************************
    localparam logic [19:0] BASE_LOAD = 20'(FILT_BASE_CYC / 8 - 1);
    localparam logic [19:0] STEP_MUL = 20'(FILT_STEP1_MUL);
    logic [19:0] tb_cnt_q;
    logic [19:0] tb_limit;
    logic [2:0] fl_code;
    logic filt_tick;
    assign fl_code = extension_mode_low[EXT_FL_LSB +: 3];
    // Code 0 is the short base; each later code doubles from 128x
    assign tb_limit = (fl_code == 3'h0) ? BASE_LOAD
                      : 20'(((BASE_LOAD + 20'h1) * STEP_MUL << (fl_code - 3'h1)) - 20'h1); // R20
    assign filt_tick = tb_cnt_q == 20'h0;
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tb_cnt_q <= 20'h0;
        end else if (filt_tick) begin
            tb_cnt_q <= tb_limit;
        end else begin
            tb_cnt_q <= tb_cnt_q - 20'h1;
        end
    end

    // ***************************************************************
    // Per-axis registers and counters
    // ***************************************************************
    logic [AXES-1:0] irq_pend;
    genvar a;
    generate
        for (a = 0; a < AXES; a++) begin : g_axis
            logic sel;
            logic [15:0] ext_lo_q, ext_hi_q, sync_lo_q, sync_hi_q;
            logic [15:0] acc_q, dec_q, home_q, evt_q;
            logic [31:0] ctr_q, lpos_q, epos_q, up_q, lo_q;
            logic [1:0] enc_prev_q;
            logic in2_prev_q;
            logic signed [31:0] cmp_src;
            logic enc_up, enc_dn, in2_act, in2_edge, enc_clr;
            logic [31:0] epos_step;
            apc_filt_if fin2 ();
            assign sel = cmd_axes[a]; // R24

            // Input two passes its own filter, group enable bit 9
            assign fin2.raw = general_input_two[a];
            assign fin2.en = ext_lo_q[EXT_FE_LSB + 1]; // R19
            assign fin2.tick = filt_tick;
            apc_filter u_filt_in2 (.clock(clock), .rst_n(rst_n_q), .f(fin2));

            assign in2_act = input_two_stop_enable[a] && (fin2.out == input_two_active_level[a]);
            assign in2_edge = in2_act && !in2_prev_q;
            assign enc_clr = ext_lo_q[EXT_ENC_CLEAR] && in2_edge; // R12
            assign stop_request[a] = enc_clr; // R12

            // Quadrature: count on each phase edge by lead direction
            logic qa, qb, pa, pb, up_raw, dn_raw;
            assign qa = encoder_plus_input[a];
            assign qb = encoder_minus_input[a];
            assign pa = enc_prev_q[0];
            assign pb = enc_prev_q[1];
            assign up_raw = enc_updown_mode[a] ? (qa && !pa)
                            : (((qa ^ pa) && (qa != qb)) || ((qb ^ pb) && (qa == qb))); // R5
            assign dn_raw = enc_updown_mode[a] ? (qb && !pb)
                            : (((qa ^ pa) && (qa == qb)) || ((qb ^ pb) && (qa != qb))); // R5
            assign enc_up = ext_lo_q[EXT_ENC_INV] ? dn_raw : up_raw; // R13
            assign enc_dn = ext_lo_q[EXT_ENC_INV] ? up_raw : dn_raw; // R13
            assign epos_step = enc_up ? 32'h1 : (enc_dn ? {neg_one, neg_one} : 32'h0);

            assign plus_pulse_out[a] = ext_lo_q[EXT_OUT_SWAP] ? pulse_minus[a] : pulse_plus[a]; // R14
            assign minus_pulse_out[a] = ext_lo_q[EXT_OUT_SWAP] ? pulse_plus[a] : pulse_minus[a]; // R14

            assign cmp_src = cmp_use_encoder[a] ? epos_q : lpos_q;
            assign upper_compare_pin[a] = cmp_src >= $signed(up_q); // R6
            assign lower_compare_pin[a] = cmp_src < $signed(lo_q); // R7
            assign compare_status_register[a*2 +: 2] = {lower_compare_pin[a], upper_compare_pin[a]};

            always_ff @(posedge clock or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    ctr_q <= 32'h0;
                    up_q <= 32'h0;
                    lo_q <= 32'h0;
                    acc_q <= ACC_OFS_RESET;
                    dec_q <= 16'h0;
                    home_q <= 16'h0;
                end else if (sel) begin
                    if (dec_center) ctr_q <= wdata; // R1
                    if (dec_upper) up_q <= wdata; // R6
                    if (dec_lower) lo_q <= wdata; // R7
                    if (dec_acc) acc_q <= write_data_low; // R8
                    if (dec_dec) dec_q <= write_data_low; // R10
                    if (dec_home) home_q <= write_data_low; // R21
                end
            end

            always_ff @(posedge clock or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    ext_lo_q <= EXT_RESET;
                    ext_hi_q <= EXT_RESET;
                    sync_lo_q <= SYNC_RESET;
                    sync_hi_q <= SYNC_RESET;
                end else if (sel && dec_ext) begin
                    ext_lo_q <= write_data_low; // R11
                    ext_hi_q <= write_data_high; // R11
                end else if (sel && dec_sync) begin
                    sync_lo_q <= write_data_low; // R22
                    sync_hi_q <= write_data_high; // R22
                end
            end

            always_ff @(posedge clock or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    lpos_q <= 32'h0;
                end else if (sel && dec_cmd_pos) begin
                    lpos_q <= wdata; // R2
                end else if (pulse_plus[a]) begin
                    lpos_q <= lpos_q + 32'h1; // R3
                end else if (pulse_minus[a]) begin
                    lpos_q <= lpos_q - 32'h1; // R3
                end
            end

            always_ff @(posedge clock or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    epos_q <= 32'h0;
                    enc_prev_q <= 2'h0;
                    in2_prev_q <= 1'b0;
                end else begin
                    enc_prev_q <= {qb, qa};
                    in2_prev_q <= in2_act;
                    if (sel && dec_enc_pos) epos_q <= wdata; // R4
                    else if (enc_clr) epos_q <= 32'h0; // R12
                    else epos_q <= epos_q + epos_step; // R5
                end
            end

            // Home end sets the flag even on the read cycle
            always_ff @(posedge clock or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    evt_q <= 16'h0;
                end else if (home_search_done[a] && ext_lo_q[EXT_HOME_IRQ]) begin
                    evt_q <= 16'h1 << EVT_HOME_END; // R16
                end else if (event_status_read[a]) begin
                    evt_q <= 16'h0; // R17
                end
            end
            assign irq_pend[a] = evt_q[EVT_HOME_END]; // R16

            assign event_status_register[a*16 +: 16] = evt_q;
            assign commanded_position_counter[a*32 +: 32] = lpos_q;
            assign encoder_position_counter[a*32 +: 32] = epos_q;
            assign circle_center[a*32 +: 32] = ctr_q;
            assign upper_compare_value[a*32 +: 32] = up_q;
            assign lower_compare_value[a*32 +: 32] = lo_q;
            assign accel_counter_offset[a*16 +: 16] = acc_q;
            assign decel_increase_rate[a*16 +: 16] = dec_q;
            assign home_search_low_speed[a*16 +: 16] = home_q;
            assign extension_mode_low[a*16 +: 16] = ext_lo_q;
            assign extension_mode_high[a*16 +: 16] = ext_hi_q;
            assign sync_action_mode_low[a*16 +: 16] = sync_lo_q;
            assign sync_action_mode_high[a*16 +: 16] = sync_hi_q;
            assign triangle_prevention[a] = ext_lo_q[EXT_TRI_PREV]; // R15
            assign variable_ring_enable[a] = ext_lo_q[EXT_VARIABLE_RING_ENABLE]; // R15
            assign speed_priority_scurve[a] = ext_lo_q[EXT_SPEED_PRI]; // R18
        end
    endgenerate

    // ***************************************************************
    // Open-drain interrupt: drive low while any axis pends
    // ***************************************************************
    assign interrupt_out_low_o = 1'b0;
    assign interrupt_out_low_oe_n = ~|irq_pend; // R17
endmodule

/* apc_pkg.sv */
// Constants for the per-axis parameter command set
// Assumes a single clock domain and four axes
package apc_pkg;
    localparam int AXES = 4;
    localparam logic [7:0] CMD_CENTER = 8'h08;
    localparam logic [7:0] CMD_CMD_POS = 8'h09;
    localparam logic [7:0] CMD_ENC_POS = 8'h0a;
    localparam logic [7:0] CMD_UPPER = 8'h0b;
    localparam logic [7:0] CMD_LOWER = 8'h0c;
    localparam logic [7:0] CMD_ACC_OFS = 8'h0d;
    localparam logic [7:0] CMD_DEC_RATE = 8'h0e;
    localparam logic [7:0] CMD_EXT_MODE = 8'h60;
    localparam logic [7:0] CMD_HOME_SPD = 8'h61;
    localparam logic [7:0] CMD_SYNC_MODE = 8'h64;
    localparam logic [15:0] ACC_OFS_RESET = 16'h0008;
    localparam logic [15:0] EXT_RESET = 16'h0000;
    localparam logic [15:0] SYNC_RESET = 16'h0000;
    localparam int EXT_ENC_CLEAR = 0;
    localparam int EXT_ENC_INV = 1;
    localparam int EXT_OUT_SWAP = 2;
    localparam int EXT_TRI_PREV = 3;
    localparam int EXT_VARIABLE_RING_ENABLE = 4;
    localparam int EXT_HOME_IRQ = 5;
    localparam int EXT_SPEED_PRI = 7;
    localparam int EXT_FE_LSB = 8;
    localparam int EXT_FL_LSB = 13;
    localparam int EVT_HOME_END = 8;
    localparam int CLK_MHZ = 40;
    localparam int CMD_BUSY_NS = 250;
    localparam int CMD_BUSY_CYC = (CMD_BUSY_NS * CLK_MHZ) / 1000;
    localparam int FILT_BASE_NS = 2000;
    localparam int FILT_BASE_CYC = (FILT_BASE_NS * CLK_MHZ) / 1000;
    localparam int FILT_STEP1_MUL = 128;
endpackage

/* apc_filt_if.sv */
// Carries one raw input and its filtered copy between modules
// Assumes the apc_pkg compile order
interface apc_filt_if;
    logic raw;
    logic en;
    logic tick;
    logic out;
    modport filt (input raw, input en, input tick, output out);
    modport user (output raw, output en, output tick, input out);
endinterface

/* apc_filter.sv */
// One input noise filter: output follows input after a stable run
// Assumes a tick pulse from the shared time-constant divider
module apc_filter (
    input wire logic clock, // System clock
    input wire logic rst_n, // Synchronised reset
    apc_filt_if.filt f // Raw input and filtered output
);
    logic [2:0] cnt_q;
    logic out_q;
    logic differs;
    assign differs = f.raw != out_q;
    assign f.out = f.en ? out_q : f.raw;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
            out_q <= 1'b1;
        end else if (!differs) begin
            cnt_q <= 3'h0;
        end else if (f.tick) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
                out_q <= f.raw;
            end
        end
    end
endmodule

/* apc_host_model.sv */
// Host CPU model: stages data words and writes command codes
// Assumes one clock and the busy flag of the interpreter
module apc_host_model
    import apc_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic cmd_busy, // Command busy
    output logic [15:0] write_data_low, // Data low
    output logic [15:0] write_data_high, // Data high
    output logic [7:0] cmd_code, // Command code
    output logic [apc_pkg::AXES-1:0] cmd_axes, // Axis select
    output logic cmd_wr // Write strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // Command write cycle
    // ****
    initial {write_data_low, write_data_high, cmd_code, cmd_axes, cmd_wr} = '0;
    task automatic issue(input logic [7:0] c, input logic [3:0] ax, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        while (cmd_busy !== 1'b0 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        write_data_low <= d[15:0];
        write_data_high <= d[31:16];
        cmd_code <= c;
        cmd_axes <= ax;
        cmd_wr <= 1'b1;
        @(posedge clock);
        cmd_wr <= 1'b0;
    endtask
endmodule

/* apc_axis_params_monitor.sv */
// Concurrent checks on the parameter command interpreter ports
// Assumes apc_pkg is compiled first; bound to apc_axis_params
module apc_axis_params_monitor
    import apc_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic arst_n, // Reset
    input wire logic [15:0] write_data_low, // Data low
    input wire logic [15:0] write_data_high, // Data high
    input wire logic [7:0] cmd_code, // Code
    input wire logic [apc_pkg::AXES-1:0] cmd_axes, // Axes
    input wire logic cmd_wr, // Strobe
    input wire logic [apc_pkg::AXES-1:0] pulse_plus, // Plus pulse
    input wire logic [apc_pkg::AXES-1:0] pulse_minus, // Minus pulse
    input wire logic [apc_pkg::AXES-1:0] home_search_done, // Home end
    input wire logic [apc_pkg::AXES-1:0] event_status_read, // Read strobe
    input wire logic [apc_pkg::AXES-1:0] plus_pulse_out, // Plus pin
    input wire logic [apc_pkg::AXES*16-1:0] event_status_register, // Events
    input wire logic interrupt_out_low_oe_n, // Irq enable
    input wire logic [apc_pkg::AXES*32-1:0] commanded_position_counter, // Cmd pos
    input wire logic [apc_pkg::AXES*32-1:0] upper_compare_value, // Upper
    input wire logic [apc_pkg::AXES*16-1:0] accel_counter_offset, // Offset
    input wire logic [apc_pkg::AXES*16-1:0] extension_mode_low, // Ext low
    input wire logic [apc_pkg::AXES*16-1:0] extension_mode_high // Ext high
);
    // ****
    // Assertions
    // ****
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    wire logic [31:0] wd = {write_data_high, write_data_low};
    AST_CMD_POS_LOAD: assert property (cmd_wr && cmd_code == CMD_CMD_POS && cmd_axes[0]
        |=> commanded_position_counter[31:0] == $past(wd)) else $error("pos load");
    AST_ACC_OFS: assert property (cmd_wr && cmd_code == CMD_ACC_OFS && cmd_axes[1]
        |=> accel_counter_offset[31:16] == $past(write_data_low)) else $error("offset load");
    AST_EXT_LOAD: assert property (cmd_wr && cmd_code == CMD_EXT_MODE && cmd_axes[3]
        |=> {extension_mode_high[63:48], extension_mode_low[63:48]} == $past(wd)) else $error("ext load");
    AST_ALL_AXES: assert property (cmd_wr && cmd_code == CMD_UPPER && cmd_axes == 4'hf
        |=> upper_compare_value == {4{$past(wd)}}) else $error("multi axis");
    AST_COUNT_UP: assert property (!cmd_wr && pulse_plus[0] |=>
        commanded_position_counter[31:0] == $past(commanded_position_counter[31:0]) + 32'h1) else $error("count up");
    AST_SWAP: assert property (!(pulse_plus[0] && pulse_minus[0]) |->
        plus_pulse_out[0] == (extension_mode_low[2] ? pulse_minus[0] : pulse_plus[0])) else $error("pulse swap");
    AST_IRQ_SET: assert property (home_search_done[1] && extension_mode_low[21] |=>
        event_status_register[24] && !interrupt_out_low_oe_n) else $error("home end irq");
    AST_EVT_CLR: assert property (event_status_read[1] && !home_search_done[1] |=>
        event_status_register[31:16] == 16'h0) else $error("status clear");
    COV_ALL: cover property (cmd_wr && cmd_axes == 4'hf);
    COV_SWAP: cover property (pulse_plus[0] && extension_mode_low[2]);
    COV_IRQ: cover property (!interrupt_out_low_oe_n);
endmodule
bind apc_axis_params apc_axis_params_monitor mon (.*);

/* tb.sv */
// Self-checking bench for the parameter command interpreter
// Assumes all other files compiled first
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import apc_pkg::*;
    logic clock, arst_n, cmd_wr, cmd_busy, interrupt_out_low_o, interrupt_out_low_oe_n;
    logic [15:0] write_data_low, write_data_high;
    logic [7:0] cmd_code, compare_status_register;
    logic [3:0] cmd_axes, pulse_plus, pulse_minus, enc_updown_mode, encoder_plus_input, encoder_minus_input;
    logic [3:0] general_input_two, input_two_stop_enable, input_two_active_level, cmp_use_encoder;
    logic [3:0] home_search_done, event_status_read, stop_request, plus_pulse_out, minus_pulse_out;
    logic [3:0] upper_compare_pin, lower_compare_pin, triangle_prevention, variable_ring_enable, speed_priority_scurve;
    logic [63:0] event_status_register, accel_counter_offset, decel_increase_rate, home_search_low_speed;
    logic [63:0] extension_mode_low, extension_mode_high, sync_action_mode_low, sync_action_mode_high;
    logic [127:0] commanded_position_counter, encoder_position_counter, circle_center;
    logic [127:0] upper_compare_value, lower_compare_value;
    logic [31:0] m [10][4];
    logic [7:0] codes [10];
    int err_total, n_tests, cyc;
    apc_axis_params dut (.*);
    apc_host_model host (.*);
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] dv(int k, int a);
        case (k)
            0: return circle_center[a*32+:32];
            1: return commanded_position_counter[a*32+:32];
            2: return encoder_position_counter[a*32+:32];
            3: return upper_compare_value[a*32+:32];
            4: return lower_compare_value[a*32+:32];
            5: return {16'h0, accel_counter_offset[a*16+:16]};
            6: return {16'h0, decel_increase_rate[a*16+:16]};
            7: return {extension_mode_high[a*16+:16], extension_mode_low[a*16+:16]};
            8: return {16'h0, home_search_low_speed[a*16+:16]};
            default: return {sync_action_mode_high[a*16+:16], sync_action_mode_low[a*16+:16]};
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc > 8000) begin
            err_total++;
            end_sim();
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        logic [31:0] d;
        logic [3:0] ax;
        int k;
        {clock, arst_n, err_total, n_tests, cyc} = '0;
        {pulse_plus, pulse_minus, encoder_plus_input, encoder_minus_input, general_input_two} = '0;
        {input_two_stop_enable, home_search_done, event_status_read} = '0;
        {enc_updown_mode, input_two_active_level} = 8'hff;
        codes = '{CMD_CENTER, CMD_CMD_POS, CMD_ENC_POS, CMD_UPPER, CMD_LOWER, CMD_ACC_OFS, CMD_DEC_RATE,
            CMD_EXT_MODE, CMD_HOME_SPD, CMD_SYNC_MODE};
        foreach (m[i, j]) m[i][j] = (i == 5) ? 32'h8 : 32'h0;
        d = $urandom(32'hbbf826d7);
        cmp_use_encoder = 4'($urandom);
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        for (int a = 0; a < 4; a++) for (k = 0; k < 10; k++) chk("reset", m[k][a], dv(k, a));
        chk("irq idle", 1, interrupt_out_low_oe_n);
        for (int it = 0; it < 20; it++) begin
            k = it % 10;
            ax = (it == 0) ? 4'hf : 4'($urandom_range(1, 15));
            d = (it < 10) ? 32'h8000_0000 : $urandom;
            if (k == 5 && it < 10) d = 0;
            if (k == 8) d = $urandom_range(1, 8000);
            if (k == 6 && d[15:0] == 16'h0) d = 1;
            host.issue(codes[k], ax, d);
            for (int a = 0; a < 4; a++) if (ax[a]) m[k][a] = (k == 5 || k == 6 || k == 8) ? {16'h0, d[15:0]} : d;
            @(posedge clock);
            #1;
            for (int a = 0; a < 4; a++) chk("param", m[k][a], dv(k, a));
            if (k == 7) chk("flags", {m[7][0][7], m[7][0][4:3]}, {speed_priority_scurve[0], variable_ring_enable[0], triangle_prevention[0]});
        end
        for (int a = 0; a < 4; a++) begin
            d = cmp_use_encoder[a] ? m[2][a] : m[1][a];
            chk("cmp", {2{$signed(d) < $signed(m[4][a]), $signed(d) >= $signed(m[3][a])}},
                {lower_compare_pin[a], upper_compare_pin[a], compare_status_register[a*2+:2]});
        end
        host.issue(CMD_EXT_MODE, 4'h1, 32'h4);
        host.issue(CMD_CMD_POS, 4'h1, 32'h5);
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            pulse_plus <= {3'h0, i < 3};
            pulse_minus <= {3'h0, i == 3};
            #1;
            chk("swap", {i == 3, i < 3}, {plus_pulse_out[0], minus_pulse_out[0]});
        end
        @(posedge clock);
        #1;
        chk("cmd pos", 32'h7, commanded_position_counter[31:0]);
        host.issue(CMD_ENC_POS, 4'h1, 32'h0);
        for (int i = 0; i < 2; i++) begin
            host.issue(CMD_EXT_MODE, 4'h1, 32'(i * 2));
            @(posedge clock);
            encoder_plus_input <= 4'h1;
            repeat (3) @(posedge clock);
            encoder_plus_input <= 4'h0;
            repeat (4) @(posedge clock);
            #1;
            chk("enc pos", 32'(1 - i), encoder_position_counter[31:0]);
        end
        host.issue(CMD_ENC_POS, 4'h1, 32'h1234);
        host.issue(CMD_EXT_MODE, 4'h1, 32'h1);
        @(posedge clock);
        input_two_stop_enable <= 4'h1;
        general_input_two <= 4'h1;
        #1;
        chk("stop pulse", 1, stop_request[0]);
        repeat (2) @(posedge clock);
        #1;
        chk("enc cleared", 0, encoder_position_counter[31:0]);
        general_input_two <= 4'h0;
        for (int i = 0; i < 2; i++) begin
            host.issue(CMD_EXT_MODE, 4'h2, 32'(i * 32));
            @(posedge clock);
            home_search_done <= 4'h2;
            @(posedge clock);
            home_search_done <= 4'h0;
            @(posedge clock);
            #1;
            chk("home end", {i[0], ~i[0]}, {event_status_register[24], interrupt_out_low_oe_n});
            event_status_read <= 4'h2;
            @(posedge clock);
            event_status_read <= 4'h0;
            @(posedge clock);
            #1;
            chk("cleared", 32'h8000, {event_status_register[31:16], interrupt_out_low_oe_n, 15'h0});
        end
        end_sim();
    end
endmodule
